// *** boundary_scan_tap.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tap_cfg.svh"

// ----------------------------------------------------------------------
// Edge event FIFO
// ----------------------------------------------------------------------
module tap_event_fifo #(
  parameter int WIDTH = `EVT_WIDTH,
  parameter int DEPTH = `EVT_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tap_event_fifo

module boundary_scan_tap (
  // System clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // Test access pins
  input  wire logic                          tckPin,
  input  wire logic                          tmsPin,
  input  wire logic                          tdiPin,
  input  wire logic                          trstPinN,
  output logic                               tdoOut,
  output logic                               tdoOeN,
  // Power-on reset from the device
  input  wire logic                          powerOnReset,
  // Pins and core signals
  input  wire logic [`BSR_IN_COUNT-1:0]      inPin,
  input  wire logic [`BSR_OUT_COUNT-1:0]     coreOut,
  output logic      [`BSR_OUT_COUNT-1:0]     outPin,
  input  wire logic [`BSR_BIDIR_COUNT-1:0]   coreBidirOut,
  input  wire logic [`BSR_BIDIR_COUNT-1:0]   coreBidirDrive,
  input  wire logic [`BSR_BIDIR_COUNT-1:0]   bidirPinIn,
  output logic      [`BSR_BIDIR_COUNT-1:0]   bidirPinOut,
  output logic      [`BSR_BIDIR_COUNT-1:0]   bidirPinOeN,
  // Test side effects on the device
  output logic                               coreTestReset,
  output logic                               weakPullupEn
);
  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  logic [1:0] tckSync_q;
  logic [1:0] tmsSync_q;
  logic [1:0] tdiSync_q;
  logic [1:0] porSync_q;
  logic       tapReset;

  // Test reset pin acts without any clock edge
  assign tapReset = reset | ~trstPinN;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tckSync_q <= 2'h0;
      tmsSync_q <= 2'h3;
      tdiSync_q <= 2'h3;
      porSync_q <= 2'h3;
    end else begin
      tckSync_q <= {tckSync_q[0], tckPin};
      tmsSync_q <= {tmsSync_q[0], tmsPin};
      tdiSync_q <= {tdiSync_q[0], tdiPin};
      porSync_q <= {porSync_q[0], powerOnReset};
    end
  end

  // --------------------------------------------------------------------
  // Test clock edge finder
  // --------------------------------------------------------------------
  // Level only advances when the event is buffered, so a full buffer
  // defers the edge instead of losing it.
  logic                  tckSeen_q;
  logic                  edgeValid;
  logic                  edgeReady;
  logic [`EVT_WIDTH-1:0] edgeWord;
  logic                  evtValid;
  logic                  evtReady;
  logic [`EVT_WIDTH-1:0] evtWord;

  assign edgeValid = (tckSync_q[1] != tckSeen_q);
  assign edgeWord  = {tckSync_q[1], tmsSync_q[1], tdiSync_q[1]};

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      tckSeen_q <= 1'b0;
    end else if (edgeValid && edgeReady) begin
      tckSeen_q <= tckSync_q[1];
    end
  end

  tap_event_fifo #(
    .WIDTH (`EVT_WIDTH),
    .DEPTH (`EVT_DEPTH)
  ) eventFifo (
    .clk      (sys_clk),
    .rst      (tapReset),
    .inValid  (edgeValid),
    .inReady  (edgeReady),
    .inData   (edgeWord),
    .outValid (evtValid),
    .outReady (evtReady),
    .outData  (evtWord)
  );

  // --------------------------------------------------------------------
  // Controller
  // --------------------------------------------------------------------
  tap_pkg::tap_state_t state_q;
  tap_pkg::tap_state_t state_d;
  logic                stall_q;
  logic                riseEvt;
  logic                fallEvt;
  logic                evtTms;
  logic                evtTdi;

  // One idle cycle after an update lets the pin muxes settle first
  assign evtReady = ~stall_q;
  assign riseEvt  = evtValid && evtReady && evtWord[`EVT_RISE_BIT];
  assign fallEvt  = evtValid && evtReady && !evtWord[`EVT_RISE_BIT];
  assign evtTms   = evtWord[`EVT_TMS_BIT];
  assign evtTdi   = evtWord[`EVT_TDI_BIT];

  function automatic tap_pkg::tap_state_t nextState(input tap_pkg::tap_state_t s,
                                                    input logic tms);
    case (s)
      tap_pkg::TEST_LOGIC_RESET: nextState = tms ? tap_pkg::TEST_LOGIC_RESET
                                                 : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::RUN_TEST_IDLE:    nextState = tms ? tap_pkg::SELECT_DR  : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::SELECT_DR:        nextState = tms ? tap_pkg::SELECT_IR  : tap_pkg::CAPTURE_DR;
      tap_pkg::CAPTURE_DR:       nextState = tms ? tap_pkg::EXIT1_DR   : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR:         nextState = tms ? tap_pkg::EXIT1_DR   : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR:         nextState = tms ? tap_pkg::UPDATE_DR  : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR:         nextState = tms ? tap_pkg::EXIT2_DR   : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR:         nextState = tms ? tap_pkg::UPDATE_DR  : tap_pkg::SHIFT_DR;
      tap_pkg::UPDATE_DR:        nextState = tms ? tap_pkg::SELECT_DR  : tap_pkg::RUN_TEST_IDLE;
      tap_pkg::SELECT_IR:        nextState = tms ? tap_pkg::TEST_LOGIC_RESET
                                                 : tap_pkg::CAPTURE_IR;
      tap_pkg::CAPTURE_IR:       nextState = tms ? tap_pkg::EXIT1_IR   : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR:         nextState = tms ? tap_pkg::EXIT1_IR   : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR:         nextState = tms ? tap_pkg::UPDATE_IR  : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR:         nextState = tms ? tap_pkg::EXIT2_IR   : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR:         nextState = tms ? tap_pkg::UPDATE_IR  : tap_pkg::SHIFT_IR;
      tap_pkg::UPDATE_IR:        nextState = tms ? tap_pkg::SELECT_DR  : tap_pkg::RUN_TEST_IDLE;
      default:                   nextState = tap_pkg::TEST_LOGIC_RESET;
    endcase
  endfunction : nextState

  always_comb begin
    state_d = state_q;
    if (porSync_q[1]) begin
      state_d = tap_pkg::TEST_LOGIC_RESET;
    end else if (riseEvt) begin
      state_d = nextState(state_q, evtTms);
    end
  end

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      state_q <= tap_pkg::TEST_LOGIC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= riseEvt && (state_q == tap_pkg::UPDATE_DR || state_q == tap_pkg::UPDATE_IR);
    end
  end

  // --------------------------------------------------------------------
  // Instruction register
  // --------------------------------------------------------------------
  logic [`IR_WIDTH-1:0] irShift_q;
  logic [`IR_WIDTH-1:0] irActive_q;

  function automatic logic bypassSelected(input logic [`IR_WIDTH-1:0] ir);
    // Reserved codes fall through to bypass with the bypass code
    bypassSelected = !(ir == `IR_EXTEST || ir == `IR_WEAK_PULLUP || ir == `IR_SAMPLE);
  endfunction : bypassSelected

  function automatic logic isExtest(input logic [`IR_WIDTH-1:0] ir);
    isExtest = (ir == `IR_EXTEST) || (ir == `IR_WEAK_PULLUP);
  endfunction : isExtest

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      irShift_q <= `IR_RESET_VALUE;
    end else if (riseEvt && state_q == tap_pkg::CAPTURE_IR) begin
      irShift_q <= `IR_CAPTURE_VALUE;
    end else if (riseEvt && state_q == tap_pkg::SHIFT_IR) begin
      irShift_q <= {evtTdi, irShift_q[`IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      irActive_q <= `IR_RESET_VALUE;
    end else if (state_q == tap_pkg::TEST_LOGIC_RESET) begin
      irActive_q <= `IR_RESET_VALUE;
    end else if (riseEvt && state_q == tap_pkg::UPDATE_IR) begin
      irActive_q <= irShift_q;
    end
  end

  // --------------------------------------------------------------------
  // Bypass and boundary-scan registers
  // --------------------------------------------------------------------
  logic                 bypass_q;
  logic [`BSR_LEN-1:0]  bsrShift_q;
  logic [`BSR_LEN-1:0]  bsrUpdate_q;
  logic [`BSR_LEN-1:0]  bsrCapture;
  logic                 bsrSel;

  assign bsrSel = !bypassSelected(irActive_q);

  // Output cells see what the pin is driving; direction cells see
  // the live drive state; they sit at the top, so the tester reads direction last.
  assign bsrCapture = {~bidirPinOeN, bidirPinIn, outPin, inPin};

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      bypass_q <= 1'b0;
    end else if (riseEvt && !bsrSel && state_q == tap_pkg::CAPTURE_DR) begin
      bypass_q <= 1'b0;
    end else if (riseEvt && !bsrSel && state_q == tap_pkg::SHIFT_DR) begin
      bypass_q <= evtTdi;
    end
  end

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      bsrShift_q <= '0;
    end else if (riseEvt && bsrSel && state_q == tap_pkg::CAPTURE_DR) begin
      bsrShift_q <= bsrCapture;
    end else if (riseEvt && bsrSel && state_q == tap_pkg::SHIFT_DR) begin
      bsrShift_q <= {evtTdi, bsrShift_q[`BSR_LEN-1:1]};
    end
  end

  // Reset leaves every direction cell at input, so no bidirectional pin is driven in scan mode until an update loads the control cells
  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      bsrUpdate_q <= '0;
    end else if (riseEvt && bsrSel && state_q == tap_pkg::UPDATE_DR) begin
      bsrUpdate_q <= bsrShift_q;
    end
  end

  // --------------------------------------------------------------------
  // Serial output, falling edge only
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      tdoOut <= 1'b0;
      tdoOeN <= 1'b1;
    end else if (fallEvt) begin
      case (state_q)
        tap_pkg::SHIFT_IR: begin
          tdoOut <= irShift_q[0];
          tdoOeN <= 1'b0;
        end
        tap_pkg::SHIFT_DR: begin
          tdoOut <= bsrSel ? bsrShift_q[0] : bypass_q;
          tdoOeN <= 1'b0;
        end
        default: begin
          tdoOeN <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Pin drive and system effects
  // --------------------------------------------------------------------
  tap_pkg::pin_mode_t pinMode;

  always_comb begin
    case (irActive_q)
      `IR_EXTEST, `IR_WEAK_PULLUP, `IR_CLAMP: pinMode = tap_pkg::PIN_SCAN;
      `IR_FLOAT_BIDIR:                        pinMode = tap_pkg::PIN_FLOAT;
      default:                                pinMode = tap_pkg::PIN_SYSTEM;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      outPin      <= '0;
      bidirPinOut <= '0;
      bidirPinOeN <= '1;
    end else begin
      case (pinMode)
        tap_pkg::PIN_SCAN: begin
          outPin      <= bsrUpdate_q[`BSR_OUT_LSB +: `BSR_OUT_COUNT];
          bidirPinOut <= bsrUpdate_q[`BSR_DATA_LSB +: `BSR_BIDIR_COUNT];
          bidirPinOeN <= ~bsrUpdate_q[`BSR_CTL_LSB +: `BSR_BIDIR_COUNT];
        end
        tap_pkg::PIN_FLOAT: begin
          outPin      <= coreOut;
          bidirPinOut <= coreBidirOut;
          bidirPinOeN <= '1;
        end
        default: begin
          outPin      <= coreOut;
          bidirPinOut <= coreBidirOut;
          bidirPinOeN <= ~coreBidirDrive;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge tapReset) begin
    if (tapReset) begin
      coreTestReset <= 1'b0;
      weakPullupEn  <= 1'b0;
    end else begin
      coreTestReset <= isExtest(irActive_q);
      weakPullupEn  <= (irActive_q == `IR_WEAK_PULLUP);
    end
  end

endmodule : boundary_scan_tap

`default_nettype wire

// *** boundary_scan_tap_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tap_cfg.svh"

module boundary_scan_tap_chk (
  // Clock and reset
  input wire logic                        sys_clk,
  input wire logic                        reset,
  // Test access pins
  input wire logic                        tckPin,
  input wire logic                        trstPinN,
  input wire logic                        powerOnReset,
  input wire logic                        tdoOut,
  input wire logic                        tdoOeN,
  // Pins and core
  input wire logic [`BSR_OUT_COUNT-1:0]   coreOut,
  input wire logic [`BSR_OUT_COUNT-1:0]   outPin,
  input wire logic [`BSR_BIDIR_COUNT-1:0] coreBidirDrive,
  input wire logic [`BSR_BIDIR_COUNT-1:0] bidirPinOeN,
  input wire logic                        coreTestReset,
  input wire logic                        weakPullupEn
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_trstClears;
    !trstPinN |-> tdoOeN && !coreTestReset && !weakPullupEn;
  endproperty
  a_trstClears: assert property (p_trstClears) else $error("test reset ignored");

  // Fall events reach tdo well inside the low phase of the test clock
  property p_tdoOnFall;
    $changed(tdoOut) && trstPinN && $past(trstPinN) |-> !tckPin;
  endproperty
  a_tdoOnFall: assert property (p_tdoOnFall) else $error("tdo moved, clock high");

  property p_oeOnFall;
    $changed(tdoOeN) && trstPinN && $past(trstPinN) |-> !tckPin;
  endproperty
  a_oeOnFall: assert property (p_oeOnFall) else $error("tdo enable moved, clock high");

  property p_porHolds;
    powerOnReset [*8] |-> !coreTestReset && !weakPullupEn;
  endproperty
  a_porHolds: assert property (p_porHolds) else $error("test mode under power-on");

  property p_pullupWithReset;
    weakPullupEn |-> coreTestReset;
  endproperty
  a_pullupWithReset: assert property (p_pullupWithReset) else $error("pullup alone");

  property p_updateOnRise;
    $rose(coreTestReset) |-> tckPin;
  endproperty
  a_updateOnRise: assert property (p_updateOnRise) else $error("update off rise");

  property p_quietWithoutTck;
    (trstPinN && !powerOnReset && $stable(tckPin)) [*8]
      |-> $stable(coreTestReset) && $stable(weakPullupEn) && $stable(tdoOeN);
  endproperty
  a_quietWithoutTck: assert property (p_quietWithoutTck) else $error("moved, no tck");

  property p_trstPinsSystem;
    !trstPinN [*2] |-> outPin == $past(coreOut) && bidirPinOeN == ~$past(coreBidirDrive);
  endproperty
  a_trstPinsSystem: assert property (p_trstPinsSystem) else $error("pins not system");
endmodule : boundary_scan_tap_chk

bind boundary_scan_tap boundary_scan_tap_chk i_chk (
  .sys_clk, .reset, .tckPin, .trstPinN, .powerOnReset, .tdoOut, .tdoOeN, .coreOut,
  .outPin, .coreBidirDrive, .bidirPinOeN, .coreTestReset, .weakPullupEn
);
`default_nettype wire

// *** boundary_scan_tap_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tap_cfg.svh"

module boundary_scan_tap_tb_top;
  typedef logic [`BSR_LEN-1:0] vec_t;
  logic                        sys_clk, reset, trstPinN, powerOnReset, drv;
  logic                        tckPin, tmsPin, tdiPin, tdoOut, tdoOeN;
  logic                        coreTestReset, weakPullupEn;
  logic [`BSR_IN_COUNT-1:0]    inPin;
  logic [`BSR_OUT_COUNT-1:0]   coreOut, outPin;
  logic [`BSR_BIDIR_COUNT-1:0] coreBidirOut, coreBidirDrive, extBidir;
  logic [`BSR_BIDIR_COUNT-1:0] bidirPinIn, bidirPinOut, bidirPinOeN;
  logic [2:0]                  xCodes[2] = '{`IR_EXTEST, `IR_WEAK_PULLUP};
  logic [2:0]                  byCodes[2] = '{3'h5, 3'h6};
  vec_t                        expQ[$];
  vec_t                        latch, nxt;
  int                          numErrors, checkCount;

  // Shared pins resolve from the design's enables
  assign bidirPinIn = (~bidirPinOeN & bidirPinOut) | (bidirPinOeN & extBidir);
  always #5 sys_clk = ~sys_clk;

  boundary_scan_tap i_dut (
    .sys_clk, .reset, .tckPin, .tmsPin, .tdiPin, .trstPinN, .tdoOut, .tdoOeN,
    .powerOnReset, .inPin, .coreOut, .outPin, .coreBidirOut, .coreBidirDrive,
    .bidirPinIn, .bidirPinOut, .bidirPinOeN, .coreTestReset, .weakPullupEn
  );
  tap_tester i_tester (.tckPin, .tmsPin, .tdiPin, .tdoOut, .tdoOeN);

  task automatic check(input vec_t seen, input vec_t exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic testDone();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : testDone

  function automatic vec_t rnd();
    vec_t r;
    r = '0;
    for (int i = 0; i < 9; i++) r = {r[240:0], $urandom()};
    return r;
  endfunction : rnd

  // Captured chain: control, pin level, output cell, input cell
  function automatic vec_t cap(input logic [28:0] o, input logic [106:0] d,
                               input logic [106:0] c);
    return {c, (c & d) | (~c & extBidir), o, inPin};
  endfunction : cap

  task automatic randPins();
    vec_t r;
    r = rnd();
    @(negedge sys_clk);
    {coreBidirOut, coreOut, inPin} = r[165:0];
    r = rnd();
    {extBidir, coreBidirDrive} = r[213:0];
    repeat (3) @(negedge sys_clk);
  endtask : randPins

  task automatic checkPins(input logic [28:0] o, input logic [106:0] d,
                           input logic [106:0] oeN, input logic [1:0] tr);
    check(vec_t'({outPin, bidirPinOut, bidirPinOeN}), vec_t'({o, d, oeN}));
    check(vec_t'({coreTestReset, weakPullupEn}), vec_t'(tr));
  endtask : checkPins

  task automatic doScan(input logic isIr, input int len, input vec_t din, input logic hold,
                        input vec_t exp);
    expQ.push_back(exp);
    i_tester.scan(isIr, len, din, hold, drv);
    check(vec_t'({drv, tdoOeN}), vec_t'({1'b1, !hold}));
  endtask : doScan

  task automatic bypassScan();
    nxt = rnd();
    doScan(1'b0, 2, nxt, 1'b0, vec_t'({nxt[0], 1'b0}));
  endtask : bypassScan

  always @(i_tester.frameDone) begin
    if (expQ.size() > 0) check(i_tester.lastOut, expQ.pop_front());
  end

  initial begin
    #400us;
    numErrors++;
    testDone();
  end

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    trstPinN = 1'b1;
    powerOnReset = 1'b0;
    {inPin, coreOut, coreBidirOut, coreBidirDrive, extBidir} = '0;
    numErrors = 0;
    checkCount = 0;
    void'($urandom(28106));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) reset = 1'b0;
    randPins();
    i_tester.toIdle();
    checkPins(coreOut, coreBidirOut, ~coreBidirDrive, 2'b00);
    bypassScan();
    doScan(1'b1, 3, vec_t'(`IR_SAMPLE), 1'b0, vec_t'(`IR_CAPTURE_VALUE));
    randPins();
    latch = rnd();
    doScan(1'b0, `BSR_LEN, latch, 1'b0, cap(coreOut, coreBidirOut, coreBidirDrive));
    checkPins(coreOut, coreBidirOut, ~coreBidirDrive, 2'b00);
    foreach (xCodes[k]) begin
      doScan(1'b1, 3, vec_t'(xCodes[k]), 1'b0, vec_t'(`IR_CAPTURE_VALUE));
      checkPins(latch[58:30], latch[165:59], ~latch[272:166], {1'b1, k == 1});
      nxt = rnd();
      doScan(1'b0, `BSR_LEN, nxt, 1'b0, cap(latch[58:30], latch[165:59], latch[272:166]));
      latch = nxt;
    end
    i_tester.slowTck = 1'b1;
    doScan(1'b1, 3, vec_t'(`IR_CLAMP), 1'b0, vec_t'(`IR_CAPTURE_VALUE));
    bypassScan();
    checkPins(latch[58:30], latch[165:59], ~latch[272:166], 2'b00);
    i_tester.slowTck = 1'b0;
    doScan(1'b1, 3, vec_t'(`IR_EXTEST), 1'b0, vec_t'(`IR_CAPTURE_VALUE));
    doScan(1'b1, 3, vec_t'(`IR_BYPASS), 1'b1, vec_t'(`IR_CAPTURE_VALUE));
    check(vec_t'(coreTestReset), vec_t'(1'b1));
    @(negedge sys_clk) trstPinN = 1'b0;
    @(negedge sys_clk);
    check(vec_t'({coreTestReset, weakPullupEn, tdoOeN}), vec_t'(3'b001));
    @(negedge sys_clk) trstPinN = 1'b1;
    i_tester.toIdle();
    doScan(1'b1, 0, '0, 1'b0, '0);
    randPins();
    checkPins(coreOut, coreBidirOut, '1, 2'b00);
    bypassScan();
    i_tester.toIdle();
    foreach (byCodes[k]) begin
      doScan(1'b1, 3, vec_t'(byCodes[k]), 1'b0, vec_t'(`IR_CAPTURE_VALUE));
      randPins();
      checkPins(coreOut, coreBidirOut, ~coreBidirDrive, 2'b00);
      bypassScan();
    end
    doScan(1'b1, 3, vec_t'(`IR_EXTEST), 1'b0, vec_t'(`IR_CAPTURE_VALUE));
    check(vec_t'(coreTestReset), vec_t'(1'b1));
    @(negedge sys_clk) powerOnReset = 1'b1;
    i_tester.scan(1'b1, 3, vec_t'(`IR_EXTEST), 1'b0, drv);
    check(vec_t'({drv, coreTestReset}), '0);
    @(negedge sys_clk) powerOnReset = 1'b0;
    repeat (3) @(negedge sys_clk);
    i_tester.toIdle();
    bypassScan();
    testDone();
  end
endmodule : boundary_scan_tap_tb_top
`default_nettype wire

// *** tap_cfg.svh ***
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH

// ----------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------
`define IR_WIDTH          3
`define IR_EXTEST         3'h0
`define IR_FLOAT_BIDIR    3'h1
`define IR_WEAK_PULLUP    3'h2
`define IR_CLAMP          3'h3
`define IR_SAMPLE         3'h4
`define IR_BYPASS         3'h7
`define IR_RESET_VALUE    3'h7
`define IR_CAPTURE_VALUE  3'h1

// ----------------------------------------------------------------------
// Boundary-scan chain layout
// ----------------------------------------------------------------------
`define BSR_IN_COUNT      30
`define BSR_OUT_COUNT     29
`define BSR_BIDIR_COUNT   107
`define BSR_LEN           273
`define BSR_IN_LSB        0
`define BSR_OUT_LSB       30
`define BSR_DATA_LSB      59
`define BSR_CTL_LSB       166

// ----------------------------------------------------------------------
// Edge event buffer
// ----------------------------------------------------------------------
`define EVT_WIDTH         3
`define EVT_DEPTH         16
`define EVT_RISE_BIT      2
`define EVT_TMS_BIT       1
`define EVT_TDI_BIT       0

`endif

// *** tap_pkg.sv ***
`default_nettype none
package tap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET = 4'h0,
    RUN_TEST_IDLE    = 4'h1,
    SELECT_DR        = 4'h2,
    CAPTURE_DR       = 4'h3,
    SHIFT_DR         = 4'h4,
    EXIT1_DR         = 4'h5,
    PAUSE_DR         = 4'h6,
    EXIT2_DR         = 4'h7,
    UPDATE_DR        = 4'h8,
    SELECT_IR        = 4'h9,
    CAPTURE_IR       = 4'hA,
    SHIFT_IR         = 4'hB,
    EXIT1_IR         = 4'hC,
    PAUSE_IR         = 4'hD,
    EXIT2_IR         = 4'hE,
    UPDATE_IR        = 4'hF
  } tap_state_t;

  typedef enum logic [1:0] {
    PIN_SYSTEM = 2'h0,
    PIN_SCAN   = 2'h1,
    PIN_FLOAT  = 2'h2
  } pin_mode_t;

endpackage : tap_pkg
`default_nettype wire

// *** tap_tester.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tap_cfg.svh"

module tap_tester (
  // Test access pins
  output logic      tckPin,
  output logic      tmsPin,
  output logic      tdiPin,
  input  wire logic tdoOut,
  input  wire logic tdoOeN
);
  logic                slowTck;
  logic                oeSeen;
  logic [`BSR_LEN-1:0] lastOut;
  event                frameDone;

  initial begin
    tckPin = 1'b0;
    tmsPin = 1'b1;
    tdiPin = 1'b1;
    slowTck = 1'b0;
  end

  // ---------------------------------------------------------------
  // One clock; tck rests low and tms/tdi fall back to pull-up level
  // ---------------------------------------------------------------
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tmsPin = tms;
    tdiPin = tdi;
    #(slowTck ? 187.5 : 62.5);
    // Released line shows the inverse, there is no pull on this pin
    tdo = tdoOeN ? !tdoOut : tdoOut;
    oeSeen = tdoOeN;
    tckPin = 1'b1;
    #62.5;
    tckPin = 1'b0;
    tmsPin = 1'b1;
    tdiPin = 1'b1;
  endtask : step

  task automatic toIdle();
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask : toIdle

  // Zero length skips the shift state; hold stays in shift
  task automatic scan(input logic isIr, input int len, input logic [`BSR_LEN-1:0] din,
                      input logic hold, output logic driven);
    logic t;
    driven = 1'b1;
    lastOut = '0;
    step(1'b1, 1'b1, t);
    if (isIr) step(1'b1, 1'b1, t);
    // Capture rise comes before the first shift rise
    step(1'b0, 1'b1, t);
    step(len == 0, 1'b1, t);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1 && !hold, din[i], t);
      lastOut[i] = t;
      driven = driven & !oeSeen;
    end
    -> frameDone;
    if (hold) return;
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask : scan
endmodule : tap_tester
`default_nettype wire
